// >>> shared/bte_consts.svh
// Purpose: Constants of the broadcast trigger enable block.
// Assumes: AXI4-Lite byte addresses, 8 address bits decoded.
// Notes: Offsets are byte addresses of aligned 32-bit words.
// Functional notes
// - Mask bits 15..12 enable ADC sample trigger outputs 15..12 on broadcast.
// - Mask bits 11..8 enable sync outputs to capture units 4..1 on broadcast.
// - Mask bits 7..5 enable one clock pulse to compare units 4..2 on broadcast.
// - Bit 4 pulses compare unit 1 clock; bits 3..0 sync compare units 4..1.
// - Mask writes are ignored while module enable and run are both set.
// - Only the control step with option 1111 consults the mask.
// - Each trigger pulse lasts pulse-width field plus one cycles.
// - Steps execute only while run is set; clearing run lifts write protection.
`ifndef BTE_CONSTS_SVH
`define BTE_CONSTS_SVH
`define BTE_MASK_OFS 8'h00
`define BTE_STAT_OFS 8'h04
`define BTE_CNT_OFS 8'h08
`define BTE_MASK_RST 16'h0000
`define BTE_CNT_RST 16'h0000
`define BTE_ADC_LSB 12
`define BTE_CAP_LSB 8
`define BTE_OCCLK_LSB 4
`define BTE_OCSYNC_LSB 0
`define BTE_ST_LOCK 0
`define BTE_ST_ACT 1
`define BTE_ST_BLK 2
`define BTE_ST_TRIG_LSB 16
`define BTE_OPT_BCAST 4'hf
`define BTE_RESP_OKAY 2'h0
`define BTE_RESP_SLVERR 2'h2
`endif

// >>> shared/bte_pkg.sv
// Purpose: Types shared by the broadcast trigger enable modules.
// Assumes: Constants come from bte_consts.svh.
// Notes: Each module keeps its state in one packed struct; bte_pulse also keeps run_len, its check counter, outside it.
package bte_pkg;
    typedef logic [15:0] bte_mask_t;
    typedef logic [3:0] bte_nib_t;
    typedef logic [7:0] bte_addr_t;
    typedef struct packed {
        bte_mask_t mask;
        logic blocked;
        logic [15:0] bcast_cnt;
    } bte_top_st_t;
    typedef struct packed {
        bte_mask_t trig;
        bte_nib_t left;
        bte_nib_t wid;
    } bte_pulse_st_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        bte_addr_t addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bte_axil_st_t;
endpackage : bte_pkg

// >>> verilog/bte_pulse.sv
// Purpose: Stretches a broadcast into trigger pulses of programmable width.
// Assumes: fire is a one-cycle strobe; width sampled with it.
// Notes: A new broadcast during a pulse restarts width and mask.
`timescale 1ns/100ps
`include "bte_consts.svh"
module bte_pulse (
    input wire logic aclk, // Sequencer clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic fire, // Broadcast step executes
    input wire bte_pkg::bte_mask_t mask, // Outputs selected
    input wire bte_pkg::bte_nib_t width, // Pulse width minus one
    output bte_pkg::bte_mask_t trig // Registered trigger outputs
);
    import bte_pkg::*;
    bte_pulse_st_t st;
    bte_pulse_st_t next_st;
    logic [4:0] run_len;

    always_comb begin
        next_st = st;
        if (fire) begin
            next_st.trig = mask;
            next_st.left = width;
            next_st.wid = width;
        end else if (st.trig != 16'h0000) begin
            if (st.left == 4'h0) begin
                next_st.trig = 16'h0000;
            end else begin
                next_st.left = st.left - 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign trig = st.trig;

    // Counts high cycles of the current pulse, only for the check below
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_len <= 5'h00;
        end else if (fire) begin
            run_len <= 5'h01;
        end else if (next_st.trig != 16'h0000) begin
            run_len <= run_len + 5'h01;
        end
    end

    property p_width;
        @(posedge aclk) disable iff (!aresetn)
        $fell(|st.trig) && !$past(fire) |-> run_len == {1'b0, st.wid} + 5'h01;
    endproperty
    a_width: assert property (p_width) else $error("Pulse width wrong");
    c_widest: cover property (@(posedge aclk) $fell(|st.trig) && st.wid == 4'hf);
endmodule : bte_pulse

// >>> verilog/bte_axil.sv
// Purpose: AXI4-Lite slave front end for the block registers.
// Assumes: One write and one read outstanding at most.
// Notes: Write happens in the first cycle in which both address and data are held.
`timescale 1ns/100ps
`include "bte_consts.svh"
module bte_axil (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire bte_pkg::bte_addr_t s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic wr_req, // Register write this cycle
    output bte_pkg::bte_addr_t wr_addr, // Held write address
    output logic [31:0] wr_data, // Held write data
    output logic [3:0] wr_strb, // Held byte enables
    input wire logic wr_err, // Write address unmapped
    input wire logic [31:0] rd_data, // Data at read address
    input wire logic rd_err // Read address unmapped
);
    import bte_pkg::*;
    bte_axil_st_t st;
    bte_axil_st_t next_st;

    always_comb begin
        next_st = st;
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.data = s_axi_wdata;
            next_st.strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_req) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_err ? `BTE_RESP_SLVERR : `BTE_RESP_OKAY;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_data;
            next_st.rresp = rd_err ? `BTE_RESP_SLVERR : `BTE_RESP_OKAY;
        end
        // Readies are registered so no ready port depends on a gate
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wr_req = st.aw_held && st.w_held && !st.bvalid;
    assign wr_addr = st.addr;
    assign wr_data = st.data;
    assign wr_strb = st.strb;
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
endmodule : bte_axil

// >>> verilog/bte_top.sv
// Purpose: Broadcast trigger enable mask and its trigger outputs.
// Assumes: Sequencer enable, run, width and step strobe are synchronous.
// Notes: Registers on AXI4-Lite: mask, status, broadcast count.
`timescale 1ns/100ps
`include "bte_consts.svh"
module bte_top (
    input wire logic aclk, // Sequencer clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire bte_pkg::bte_addr_t s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire bte_pkg::bte_addr_t s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic sequencer_module_enable, // Module enabled
    input wire logic sequencer_run, // Sequencer executing steps
    input wire bte_pkg::bte_nib_t trig_pulse_width, // Pulse width minus one
    input wire logic control_step_cmd, // Control step executes, one cycle
    input wire bte_pkg::bte_nib_t step_option, // Option of that step
    output bte_pkg::bte_nib_t adc_sample_trig, // Trigger outputs 15..12
    output bte_pkg::bte_nib_t capture_sync, // Capture units 4..1
    output bte_pkg::bte_nib_t compare_clk_pulse, // Compare units 4..1 clock
    output bte_pkg::bte_nib_t compare_sync // Compare units 4..1 sync
);
    import bte_pkg::*;
    bte_top_st_t st;
    bte_top_st_t next_st;
    logic locked;
    logic fire;
    logic wr_req;
    bte_addr_t wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [31:0] rd_data;
    logic rd_err;
    bte_mask_t trig;
    logic mask_wr;
    logic stat_clr;
    logic rd_take;

    // Protection follows the live enable and run levels, so it ends the
    // moment run is cleared, even in the middle of a pulse.
    assign locked = sequencer_module_enable && sequencer_run;
    // Steps only execute while running; other options never reach the mask.
    assign fire = locked && control_step_cmd
        && step_option == `BTE_OPT_BCAST;
    assign mask_wr = wr_req && wr_addr == `BTE_MASK_OFS;
    assign wr_err = !(wr_addr == `BTE_MASK_OFS || wr_addr == `BTE_STAT_OFS);
    // Writing one to the refused flag clears it
    assign stat_clr = wr_req && wr_addr == `BTE_STAT_OFS && wr_strb[0]
        && wr_data[`BTE_ST_BLK];
    // Read handshake edge; read data are captured there
    assign rd_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        next_st = st;
        if (mask_wr && !locked) begin
            for (int b = 0; b < 2; b++) begin
                if (wr_strb[b]) begin
                    next_st.mask[b*8 +: 8] = wr_data[b*8 +: 8];
                end
            end
        end
        // A refused write in the same cycle wins over the clear
        if (stat_clr) begin
            next_st.blocked = 1'b0;
        end
        if (mask_wr && locked) begin
            next_st.blocked = 1'b1;
        end
        if (fire) begin
            next_st.bcast_cnt = st.bcast_cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st.mask <= `BTE_MASK_RST;
            st.blocked <= 1'b0;
            st.bcast_cnt <= `BTE_CNT_RST;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (s_axi_araddr)
            `BTE_MASK_OFS: begin
                rd_data[15:0] = st.mask;
            end
            `BTE_STAT_OFS: begin
                rd_data[`BTE_ST_LOCK] = locked;
                rd_data[`BTE_ST_ACT] = trig != 16'h0000;
                rd_data[`BTE_ST_BLK] = st.blocked;
                rd_data[`BTE_ST_TRIG_LSB +: 16] = trig;
            end
            `BTE_CNT_OFS: begin
                rd_data[15:0] = st.bcast_cnt;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    bte_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_req(wr_req),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    bte_pulse u_pulse (
        .aclk(aclk),
        .aresetn(aresetn),
        .fire(fire),
        .mask(st.mask),
        .width(trig_pulse_width),
        .trig(trig)
    );

    // Outputs are slices of the pulse register, one flip-flop per line
    assign adc_sample_trig = trig[`BTE_ADC_LSB +: 4];
    assign capture_sync = trig[`BTE_CAP_LSB +: 4];
    assign compare_clk_pulse = trig[`BTE_OCCLK_LSB +: 4];
    assign compare_sync = trig[`BTE_OCSYNC_LSB +: 4];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_adc;
        fire |=> adc_sample_trig == $past(st.mask[15:12]);
    endproperty
    a_adc: assert property (p_adc) else $error("ADC triggers differ from mask");

    property p_cap;
        fire |=> capture_sync == $past(st.mask[11:8]);
    endproperty
    a_cap: assert property (p_cap) else $error("Capture sync differs from mask");

    property p_occlk;
        fire |=> compare_clk_pulse[3:1] == $past(st.mask[7:5]);
    endproperty
    a_occlk: assert property (p_occlk) else $error("Compare clocks 4..2 wrong");

    property p_oc1;
        fire |=> {compare_clk_pulse[0], compare_sync} == $past(st.mask[4:0]);
    endproperty
    a_oc1: assert property (p_oc1) else $error("Compare 1 clock or syncs wrong");

    property p_lock;
        mask_wr && locked |=> $stable(st.mask) && st.blocked;
    endproperty
    a_lock: assert property (p_lock) else $error("Mask changed while locked");

    property p_opt;
        control_step_cmd && step_option != `BTE_OPT_BCAST && trig == 16'h0000
            |=> trig == 16'h0000;
    endproperty
    a_opt: assert property (p_opt) else $error("Non-broadcast step fired");

    property p_run;
        !sequencer_run && trig == 16'h0000 |=> trig == 16'h0000 && $stable(st.bcast_cnt);
    endproperty
    a_run: assert property (p_run) else $error("Broadcast while stopped");

    property p_unlock;
        mask_wr && !locked && wr_strb == 4'hf |=> st.mask == $past(wr_data[15:0]);
    endproperty
    a_unlock: assert property (p_unlock) else $error("Unlocked write lost");

    property p_all;
        fire |=> trig == $past(st.mask);
    endproperty
    a_all: assert property (p_all) else $error("Selected outputs not together");

    // Lines rise only on a taken broadcast and drop together at the end
    property p_quiet;
        !fire && trig == 16'h0000 |=> trig == 16'h0000;
    endproperty
    a_quiet: assert property (p_quiet) else $error("Line rose without broadcast");

    property p_hold;
        !fire && trig != 16'h0000 |=> trig == 16'h0000 || trig == $past(trig);
    endproperty
    a_hold: assert property (p_hold) else $error("Lines changed inside a pulse");

    property p_en_quiet;
        !sequencer_module_enable && trig == 16'h0000 |=> trig == 16'h0000;
    endproperty
    a_en_quiet: assert property (p_en_quiet) else $error("Broadcast while disabled");

    // Exactly one count per taken broadcast; it wraps
    property p_cnt;
        fire |=> st.bcast_cnt == $past(st.bcast_cnt) + 16'h0001;
    endproperty
    a_cnt: assert property (p_cnt) else $error("Broadcast not counted");

    property p_cnt_hold;
        !fire |=> $stable(st.bcast_cnt);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("Count moved by itself");

    // Sticky flag: set only by a refused write, cleared only by software
    property p_blk_clear;
        stat_clr |=> !st.blocked;
    endproperty
    a_blk_clear: assert property (p_blk_clear) else $error("Refused flag not cleared");

    property p_blk_hold;
        !stat_clr && !(mask_wr && locked) |=> $stable(st.blocked);
    endproperty
    a_blk_hold: assert property (p_blk_hold) else $error("Refused flag moved");

    // A refused write still answers OKAY, so software never stalls on it
    property p_lock_resp;
        mask_wr && locked |=> s_axi_bvalid && s_axi_bresp == `BTE_RESP_OKAY;
    endproperty
    a_lock_resp: assert property (p_lock_resp) else $error("Refused write answer wrong");

    property p_unmapped;
        wr_req && wr_err |=> s_axi_bresp == `BTE_RESP_SLVERR && $stable(st.mask);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped write answer wrong");

    // Byte enables pick which half of the mask a write may touch
    property p_wr_lo;
        mask_wr && !locked && wr_strb[0] |=> st.mask[7:0] == $past(wr_data[7:0]);
    endproperty
    a_wr_lo: assert property (p_wr_lo) else $error("Low mask byte not written");

    property p_wr_hi;
        mask_wr && !locked && !wr_strb[1] |=> $stable(st.mask[15:8]);
    endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("High mask byte written");

    // Reads stay open while the mask is locked
    property p_rd_mask;
        rd_take && s_axi_araddr == `BTE_MASK_OFS
            |=> s_axi_rdata == {16'h0000, $past(st.mask)} && s_axi_rresp == `BTE_RESP_OKAY;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("Mask read wrong");

    // Status bits as they stood at the read handshake edge
    property p_rd_stat;
        rd_take && s_axi_araddr == `BTE_STAT_OFS
            |=> s_axi_rdata[`BTE_ST_LOCK] == $past(locked)
            && s_axi_rdata[`BTE_ST_BLK] == $past(st.blocked);
    endproperty
    a_rd_stat: assert property (p_rd_stat) else $error("Status read wrong");

    property p_rd_trig;
        rd_take && s_axi_araddr == `BTE_STAT_OFS
            |=> s_axi_rdata[31:16] == $past(trig);
    endproperty
    a_rd_trig: assert property (p_rd_trig) else $error("Status lines wrong");

    property p_rd_cnt;
        rd_take && s_axi_araddr == `BTE_CNT_OFS
            |=> s_axi_rdata == {16'h0000, $past(st.bcast_cnt)};
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("Count read wrong");

    // Main scenarios the bench should reach
    c_all_on: cover property (fire && st.mask == 16'hffff);
    c_refused: cover property (mask_wr && locked);
    c_refire: cover property (fire ##[1:16] fire);
    c_other_opt: cover property (locked && control_step_cmd && step_option != `BTE_OPT_BCAST);
endmodule : bte_top

// >>> testbench/bte_periph_model.sv
// Purpose: Far-side model of the peripherals that take the broadcast trigger lines.
// Assumes: Lines are sampled on the sequencer clock, ordered as the mask bits.
// Notes: Receivers only listen; they never answer or stall the sequencer.
`timescale 1ns/100ps
module bte_periph_model (
    input wire logic aclk, // Sequencer clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire bte_pkg::bte_mask_t trig, // Trigger lines 15..0
    output bte_pkg::bte_mask_t seen, // Lines that fired since reset
    output logic [15:0] rises // Rising edges over all lines
);
    import bte_pkg::*;
    bte_mask_t prev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= 16'h0000;
            seen <= 16'h0000;
            rises <= 16'h0000;
        end else begin
            prev <= trig;
            seen <= seen | trig;
            // Count edges, not levels, so a long pulse still counts as one trigger
            rises <= rises + 16'($countones(trig & ~prev));
        end
    end
endmodule : bte_periph_model

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the broadcast trigger enable block.
// Assumes: AXI4-Lite master tasks; sequencer inputs driven by the bench.
// Notes: Random masks and widths from a fixed seed, with corner values first.
`timescale 1ns/100ps
`include "bte_consts.svh"
module testbench;
    import bte_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    bte_addr_t s_axi_awaddr = 8'h00;
    bte_addr_t s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic sequencer_module_enable = 1'b0, sequencer_run = 1'b0, control_step_cmd = 1'b0;
    bte_nib_t trig_pulse_width = 4'h0, step_option = 4'h0;
    bte_nib_t adc_sample_trig, capture_sync, compare_clk_pulse, compare_sync;
    bte_mask_t trig_all, model_seen, exp_seen, cur, m;
    logic [15:0] model_rises, exp_rises, nb;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [3:0] st;
    bte_nib_t w;
    integer seed;
    int compares = 0, miscompares = 0, k;
    always #2 aclk = ~aclk;
    assign trig_all = {adc_sample_trig, capture_sync, compare_clk_pulse, compare_sync};
    bte_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sequencer_module_enable(sequencer_module_enable),
        .sequencer_run(sequencer_run), .trig_pulse_width(trig_pulse_width),
        .control_step_cmd(control_step_cmd), .step_option(step_option),
        .adc_sample_trig(adc_sample_trig), .capture_sync(capture_sync),
        .compare_clk_pulse(compare_clk_pulse), .compare_sync(compare_sync));
    bte_periph_model u_periph (.aclk(aclk), .aresetn(aresetn), .trig(trig_all),
        .seen(model_seen), .rises(model_rises));

    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_up();
        miscompares++;
        print_verdict();
    endtask : give_up

    task automatic axi_write(input bte_addr_t a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 64) give_up();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input bte_addr_t a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 64) give_up();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // One control step; exp is what the lines must show for width+1 cycles
    task automatic fire(input bte_nib_t opt, input bte_nib_t wd, input bte_mask_t exp);
        int i;
        @(posedge aclk);
        control_step_cmd <= 1'b1;
        step_option <= opt;
        trig_pulse_width <= wd;
        @(posedge aclk);
        control_step_cmd <= 1'b0;
        // Values read at an edge are the ones the previous edge launched
        for (i = 0; i <= int'(wd); i++) begin
            @(posedge aclk);
            chk("trigger lines", 32'(trig_all), 32'(exp));
        end
        @(posedge aclk);
        chk("trigger lines after pulse", 32'(trig_all), 32'h0);
    endtask : fire

    function automatic logic [15:0] ones(input bte_mask_t v);
        return 16'($countones(v));
    endfunction : ones

    initial begin
        seed = 80;
        cur = 16'h0000;
        exp_seen = 16'h0000;
        exp_rises = 16'h0000;
        nb = 16'h0000;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`BTE_MASK_OFS, rd, rs);
        chk("mask after reset", rd, 32'h0);
        chk("mask read response", 32'(rs), 32'(`BTE_RESP_OKAY));
        sequencer_module_enable <= 1'b1;
        for (k = 0; k < 14; k++) begin
            m = (k == 0) ? 16'hffff : (k == 1) ? 16'h0001 : 16'($random(seed));
            w = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($random(seed));
            st = (k == 2) ? 4'h1 : 4'hf;
            axi_write(`BTE_MASK_OFS, {16'($random(seed)), m}, st, rs);
            cur = {st[1] ? m[15:8] : cur[15:8], st[0] ? m[7:0] : cur[7:0]};
            axi_read(`BTE_MASK_OFS, rd, rs);
            chk("mask readback", rd, {16'h0, cur});
            sequencer_run <= 1'b1;
            fire(`BTE_OPT_BCAST, w, cur);
            nb = nb + 16'h1;
            exp_seen = exp_seen | cur;
            exp_rises = exp_rises + ones(cur);
            sequencer_run <= 1'b0;
        end
        sequencer_run <= 1'b1;
        for (k = 0; k < 15; k++) begin
            fire(4'(k), 4'h1, 16'h0);
        end
        axi_write(`BTE_MASK_OFS, 32'h0000a5c3, 4'hf, rs);
        chk("locked write response", 32'(rs), 32'(`BTE_RESP_OKAY));
        axi_read(`BTE_MASK_OFS, rd, rs);
        chk("mask while locked", rd, {16'h0, cur});
        axi_read(`BTE_STAT_OFS, rd, rs);
        chk("lock and refused flags", rd & 32'h5, 32'h5);
        axi_write(`BTE_STAT_OFS, 32'h4, 4'h1, rs);
        axi_read(`BTE_STAT_OFS, rd, rs);
        chk("status after flag clear", rd, 32'h1);
        sequencer_run <= 1'b0;
        fire(`BTE_OPT_BCAST, 4'h2, 16'h0);
        sequencer_module_enable <= 1'b0;
        sequencer_run <= 1'b1;
        fire(`BTE_OPT_BCAST, 4'h2, 16'h0);
        sequencer_run <= 1'b0;
        sequencer_module_enable <= 1'b1;
        axi_write(`BTE_MASK_OFS, 32'h0000a5c3, 4'hf, rs);
        axi_read(`BTE_MASK_OFS, rd, rs);
        chk("mask after run cleared", rd, 32'h0000a5c3);
        axi_write(8'h0c, 32'h1, 4'hf, rs);
        chk("unmapped write response", 32'(rs), 32'(`BTE_RESP_SLVERR));
        axi_read(8'h0c, rd, rs);
        chk("unmapped read response", 32'(rs), 32'(`BTE_RESP_SLVERR));
        chk("unmapped read data", rd, 32'h0);
        axi_write(`BTE_CNT_OFS, 32'h1, 4'hf, rs);
        chk("count write response", 32'(rs), 32'(`BTE_RESP_SLVERR));
        axi_read(`BTE_CNT_OFS, rd, rs);
        chk("broadcast count", rd, {16'h0, nb});
        chk("lines seen by peripherals", 32'(model_seen), 32'(exp_seen));
        chk("trigger edges at peripherals", 32'(model_rises), 32'(exp_rises));
        print_verdict();
    end
endmodule : testbench
